// File: design/rsc_defs.svh
// constants for the reset source controller: offsets, fields, reset values, timings
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

`define RSC_ADDR_CAUSE    4'h0
`define RSC_ADDR_SCRATCH  4'h1
`define RSC_ADDR_STATUS   4'h2

`define RSC_CAUSE_POR_VAL 16'h0003
`define RSC_CAUSE_WMASK   16'hc7ff
`define RSC_B_TRAP        15
`define RSC_B_OPCODE      14
`define RSC_B_DSLEEP      10
`define RSC_B_CFG         9
`define RSC_B_FBIAS       8
`define RSC_B_PIN         7
`define RSC_B_INSTR       6
`define RSC_B_SWDT        5
`define RSC_B_WATCHDOG_TIMEOUT_FLAG        4
`define RSC_B_SLEEP       3
`define RSC_B_IDLE        2
`define RSC_B_BOR         1

`define RSC_CLK_NS        100
`define RSC_TPOR_NS       10000
`define RSC_TRST_NS       1000
`define RSC_TPWRT_NS      64000000
`define RSC_TFSCM_NS      2000
`define RSC_CYC(t)        (((t) + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_OST_PERIODS   1024

`endif

// File: design/rsc_pkg.sv
// types shared by the reset source controller
package rsc_pkg;
  typedef enum logic [2:0] {
    ST_POR,
    ST_HOLD,
    ST_TRST,
    ST_POWER_UP_TIMER,
    ST_RUN
  } seq_state_e;
  typedef logic [2:0] osc_sel_t;
endpackage : rsc_pkg

// File: design/reset_source_controller.sv
// reset source merge, reset cause register, release sequencing and clock select
//
// Added by the designer: the register addresses and the address-and-strobe port.
`include "rsc_defs.svh"
module reset_source_controller
  import rsc_pkg::*;
#(
  parameter int unsigned POR_CYCLES  = `RSC_CYC(`RSC_TPOR_NS),
  parameter int unsigned POWER_UP_TIMER_CYCLES = `RSC_CYC(`RSC_TPWRT_NS),
  parameter int unsigned FAILSAFE_CLOCK_MONITOR_CYCLES = `RSC_CYC(`RSC_TFSCM_NS)
)(
  // clock, power-on reset, enable
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // asynchronous monitors and pins
  input  wire logic        external_reset_pin_n,
  input  wire logic        brown_out_reset,
  input  wire logic        osc_tick,
  input  wire logic        pll_locked,
  // core events, system clock domain
  input  wire logic        instr_reset,
  input  wire logic        watchdog_timeout,
  input  wire logic        config_mismatch,
  input  wire logic        trap_conflict,
  input  wire logic        bad_opcode,
  input  wire logic        uninit_register_reset,
  input  wire logic        power_save_instruction_sleep,
  input  wire logic        power_save_instruction_idle,
  input  wire logic        deep_sleep_enable,
  // configuration
  input  wire logic        fuse_watchdog_enable,
  input  wire logic        clock_switch_enable,
  input  wire logic [2:0]  fuse_oscillator_select,
  input  wire logic [2:0]  current_oscillator_field,
  input  wire logic        pll_in_use,
  // outputs
  output logic             master_reset_n,
  output logic             code_run,
  output logic      [2:0]  reset_clock_select,
  output logic             watchdog_enable,
  output logic             flash_bias_in_sleep,
  output logic             regulator_standby_in_sleep,
  output logic             failsafe_monitor_en
);

  localparam int unsigned TRST_CYCLES = `RSC_CYC(`RSC_TRST_NS);
  localparam logic [9:0]  OST_LAST    = 10'(`RSC_OST_PERIODS - 1);

  // two-stage synchronisers; pin inverted ahead of the first stage
  logic [3:0] async_in;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  assign async_in = {pll_locked, osc_tick, brown_out_reset, ~external_reset_pin_n};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      always_ff @(posedge clk_sys or negedge arst_n)
      begin
        if (!arst_n)
        begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end
        else if (clk_en)
        begin
          sync1_q[gi] <= async_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  // limitation: each osc_tick phase must last a full system clock to be counted
  logic pin_rst;
  logic bor_rst;
  logic tick_s;
  logic lock_s;
  assign pin_rst = sync2_q[0];
  assign bor_rst = sync2_q[1];
  assign tick_s  = sync2_q[2];
  assign lock_s  = sync2_q[3];

  logic any_src;
  assign any_src = pin_rst | bor_rst | instr_reset | watchdog_timeout
                 | config_mismatch | trap_conflict | bad_opcode
                 | uninit_register_reset;

  // register access decode
  logic wr_cause;
  logic wr_scratch;
  assign wr_cause   = reg_wr && (reg_addr == `RSC_ADDR_CAUSE);
  assign wr_scratch = reg_wr && (reg_addr == `RSC_ADDR_SCRATCH);

  // reset cause register
  logic [15:0] cause_q;
  logic [15:0] cause_d;

  always_comb
  begin
    cause_d = cause_q;
    if (wr_cause)
    begin
      // plain storage; a written one starts no reset
      cause_d = reg_wdata & `RSC_CAUSE_WMASK;
      // deep-sleep flag can only be cleared by software
      cause_d[`RSC_B_DSLEEP] = cause_q[`RSC_B_DSLEEP] & reg_wdata[`RSC_B_DSLEEP];
    end
    if (power_save_instruction_sleep || power_save_instruction_idle)
      cause_d[`RSC_B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
    // hardware sets come last so an event beats a same-cycle clear
    if (trap_conflict)
      cause_d[`RSC_B_TRAP] = 1'b1;
    if (bad_opcode || uninit_register_reset)
      cause_d[`RSC_B_OPCODE] = 1'b1;
    if (power_save_instruction_sleep && deep_sleep_enable)
      cause_d[`RSC_B_DSLEEP] = 1'b1;
    if (config_mismatch)
      cause_d[`RSC_B_CFG] = 1'b1;
    if (pin_rst)
      cause_d[`RSC_B_PIN] = 1'b1;
    if (instr_reset)
      cause_d[`RSC_B_INSTR] = 1'b1;
    if (watchdog_timeout)
      cause_d[`RSC_B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
    if (power_save_instruction_sleep)
      cause_d[`RSC_B_SLEEP] = 1'b1;
    if (power_save_instruction_idle)
      cause_d[`RSC_B_IDLE] = 1'b1;
    // bit 0 has no hardware setter here: the power-on reset and a software write raise it
    if (bor_rst)
      cause_d[`RSC_B_BOR] = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      cause_q <= `RSC_CAUSE_POR_VAL;
    else if (clk_en)
      cause_q <= cause_d;
  end

  // general storage with no reset: survives every reset but power loss
  logic [15:0] scratch_q;
  always_ff @(posedge clk_sys)
  begin
    if (clk_en && wr_scratch)
      scratch_q <= reg_wdata;
  end

  // release sequencer
  seq_state_e  state_q;
  logic [19:0] cnt_q;
  logic        long_q;
  logic        from_por_q;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q    <= ST_POR;
      cnt_q      <= 20'(POR_CYCLES - 1);
      long_q     <= 1'b1;
      from_por_q <= 1'b1;
    end
    else if (clk_en)
    begin
      if (any_src)
      begin
        // every source restarts the sequence and holds it
        state_q <= ST_HOLD;
        cnt_q   <= 20'(TRST_CYCLES - 1);
        // power-up timer is owed again after a brown-out only
        if (bor_rst)
          long_q <= 1'b1;
        else if (state_q == ST_RUN)
          long_q <= 1'b0;
        // a source during the power-on count keeps the fuse clock choice
        if (state_q != ST_POR)
          from_por_q <= 1'b0;
      end
      else
      begin
        case (state_q)
          ST_POR:
          begin
            if (cnt_q == 20'h00000)
            begin
              state_q <= ST_TRST;
              cnt_q   <= 20'(TRST_CYCLES - 1);
            end
            else
              cnt_q <= cnt_q - 20'h00001;
          end
          ST_HOLD:
          begin
            state_q <= ST_TRST;
            cnt_q   <= 20'(TRST_CYCLES - 1);
          end
          ST_TRST:
          begin
            if (cnt_q != 20'h00000)
              cnt_q <= cnt_q - 20'h00001;
            else if (long_q)
            begin
              state_q <= ST_POWER_UP_TIMER;
              cnt_q   <= 20'(POWER_UP_TIMER_CYCLES - 1);
            end
            else
              state_q <= ST_RUN;
          end
          ST_POWER_UP_TIMER:
          begin
            if (cnt_q == 20'h00000)
              state_q <= ST_RUN;
            else
              cnt_q <= cnt_q - 20'h00001;
          end
          ST_RUN:
            cnt_q <= 20'h00000;
          default:
            state_q <= ST_HOLD;
        endcase
      end
    end
  end

  // clean, clock-aligned master reset; asserts at once under power-on
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      master_reset_n <= 1'b0;
    else if (clk_en)
      // sources gate the output directly, saving a cycle of latency
      master_reset_n <= (state_q == ST_RUN) && !any_src;
  end

  // reset clock source, chosen by the kind of reset
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      reset_clock_select <= 3'h0;
    else if (clk_en)
    begin
      if (!clock_switch_enable)
        reset_clock_select <= fuse_oscillator_select;
      else if (state_q == ST_POR || from_por_q)
        reset_clock_select <= fuse_oscillator_select;
      else if (any_src && (pin_rst || watchdog_timeout || instr_reset))
        reset_clock_select <= current_oscillator_field;
      // limitation: all other sources fall back to the fuse value
      else if (any_src)
        reset_clock_select <= fuse_oscillator_select;
    end
  end

  // oscillator start-up timer; only a supply loss restarts it
  logic       tick_d_q;
  logic [9:0] ost_cnt_q;
  logic       ost_done_q;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tick_d_q   <= 1'b0;
      ost_cnt_q  <= 10'h000;
      ost_done_q <= 1'b0;
    end
    else if (clk_en)
    begin
      tick_d_q <= tick_s;
      // core resets leave the oscillator alive, so the count is kept
      if (bor_rst)
      begin
        ost_cnt_q  <= 10'h000;
        ost_done_q <= 1'b0;
      end
      else if (tick_s && !tick_d_q && !ost_done_q)
      begin
        // counts oscillator periods in parallel with the reset delay
        if (ost_cnt_q == OST_LAST)
          ost_done_q <= 1'b1;
        else
          ost_cnt_q <= ost_cnt_q + 10'h001;
      end
    end
  end

  // code runs only once a valid clock is released
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      code_run <= 1'b0;
    else if (clk_en)
      // lock only matters while the pll sits in the clock path
      code_run <= master_reset_n && ost_done_q && (!pll_in_use || lock_s);
  end

  // fail-safe monitor start delay, counted from release
  logic [19:0] failsafe_clock_monitor_cnt_q;
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      failsafe_clock_monitor_cnt_q          <= 20'h00000;
      failsafe_monitor_en <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!master_reset_n)
      begin
        failsafe_clock_monitor_cnt_q          <= 20'h00000;
        failsafe_monitor_en <= 1'b0;
      end
      // count parks at its end; a new release starts it over
      else if (failsafe_clock_monitor_cnt_q == 20'(FAILSAFE_CLOCK_MONITOR_CYCLES - 1))
        failsafe_monitor_en <= 1'b1;
      else
        failsafe_clock_monitor_cnt_q <= failsafe_clock_monitor_cnt_q + 20'h00001;
    end
  end

  // control outputs taken from the cause register
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      watchdog_enable            <= 1'b0;
      flash_bias_in_sleep        <= 1'b0;
      regulator_standby_in_sleep <= 1'b1;
    end
    else if (clk_en)
    begin
      // a programmed fuse forces the watchdog on; software chooses only while the fuse is clear
      watchdog_enable            <= fuse_watchdog_enable | cause_q[`RSC_B_SWDT];
      flash_bias_in_sleep        <= cause_q[`RSC_B_FBIAS];
      regulator_standby_in_sleep <= ~cause_q[`RSC_B_FBIAS];
    end
  end

  // read data valid only in the cycle after the strobe
  logic [15:0] status_w;
  assign status_w = {9'h000, reset_clock_select, failsafe_monitor_en,
                     code_run, ost_done_q, master_reset_n};

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 16'h0000;
    else if (clk_en)
    begin
      if (reg_rd)
      begin
        case (reg_addr)
          `RSC_ADDR_CAUSE:   reg_rdata <= cause_q;
          `RSC_ADDR_SCRATCH: reg_rdata <= scratch_q;
          `RSC_ADDR_STATUS:  reg_rdata <= status_w;
          default:           reg_rdata <= 16'h0000;
        endcase
      end
      // zero outside the answer cycle, so stale words never look valid
      else
        reg_rdata <= 16'h0000;
    end
  end

endmodule : reset_source_controller

// File: dv/rsc_monitor.sv
// assertion checker on the reset source controller ports
module rsc_monitor #(
  parameter int unsigned POR_CYCLES  = 5,
  parameter int unsigned POWER_UP_TIMER_CYCLES = 20,
  parameter int unsigned FAILSAFE_CLOCK_MONITOR_CYCLES = 3
)(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire logic       clk_en,
  // reset sources
  input wire logic       instr_reset,
  input wire logic       watchdog_timeout,
  input wire logic       config_mismatch,
  input wire logic       trap_conflict,
  input wire logic       bad_opcode,
  input wire logic       uninit_register_reset,
  input wire logic       external_reset_pin_n,
  input wire logic       brown_out_reset,
  // configuration
  input wire logic       fuse_watchdog_enable,
  input wire logic       clock_switch_enable,
  input wire logic [2:0] fuse_oscillator_select,
  // outputs
  input wire logic       master_reset_n,
  input wire logic       code_run,
  input wire logic [2:0] reset_clock_select,
  input wire logic       watchdog_enable,
  input wire logic       flash_bias_in_sleep,
  input wire logic       regulator_standby_in_sleep,
  input wire logic       failsafe_monitor_en,
  // clock validity
  input wire logic       pll_locked,
  input wire logic       pll_in_use
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FAILSAFE_CLOCK_MONITOR_D = FAILSAFE_CLOCK_MONITOR_CYCLES - 1;
  localparam int LONG_D = POR_CYCLES + POWER_UP_TIMER_CYCLES + 10;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic        core_src;
  logic [31:0] low_q;
  logic        first_q;
  assign core_src = clk_en && (instr_reset || watchdog_timeout || config_mismatch
                    || trap_conflict || bad_opcode || uninit_register_reset);
  // only the release after power-on is checked against the long delay
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      first_q <= 1'b1;
    else if (master_reset_n)
      first_q <= 1'b0;
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      low_q <= '0;
    else if (master_reset_n)
      low_q <= '0;
    else
      low_q <= low_q + 1;
  sequence s_release;
    $rose(master_reset_n);
  endsequence
  sequence s_monitor_on;
    !failsafe_monitor_en ##FAILSAFE_CLOCK_MONITOR_D !failsafe_monitor_en ##1 failsafe_monitor_en;
  endsequence
  property p_core;
    core_src |=> ##[0:1] !master_reset_n;
  endproperty
  property p_async;
    !external_reset_pin_n || brown_out_reset |-> ##[1:6] !master_reset_n;
  endproperty
  property p_bias;
    flash_bias_in_sleep != regulator_standby_in_sleep;
  endproperty
  property p_wdt;
    fuse_watchdog_enable |=> watchdog_enable;
  endproperty
  property p_fixed_clk;
    (!clock_switch_enable) [*2] |-> reset_clock_select == $past(fuse_oscillator_select);
  endproperty
  property p_release;
    s_release |-> low_q >= (first_q ? LONG_D : 10);
  endproperty
  property p_failsafe_clock_monitor;
    s_release |-> s_monitor_on;
  endproperty
  property p_run;
    $rose(code_run) |-> master_reset_n && (!pll_in_use || $past(pll_locked, 3));
  endproperty
  property p_stop;
    $fell(master_reset_n) |-> ##[0:1] !code_run;
  endproperty
  a_core: assert property (p_core) else $error("no master reset after core source");
  a_async: assert property (p_async) else $error("no master reset after pin or brown-out");
  a_bias: assert property (p_bias) else $error("bias and standby agree");
  a_wdt: assert property (p_wdt) else $error("watchdog off with fuse set");
  a_fixed_clk: assert property (p_fixed_clk) else $error("select not fuse");
  a_release: assert property (p_release) else $error("master reset released early");
  a_failsafe_clock_monitor: assert property (p_failsafe_clock_monitor) else $error("clock monitor start wrong");
  a_run: assert property (p_run) else $error("code runs in reset");
  a_stop: assert property (p_stop) else $error("code runs on after reset");
endmodule : rsc_monitor

// File: dv/osc_model.sv
// oscillator and pll as seen by the reset controller
module osc_model (
  // oscillator side
  output logic osc_tick,
  output logic pll_locked
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    osc_tick = 1'b0;
    pll_locked = 1'b0;
    // locks after the start-up timer is done, so code_run waits on the lock
    #500000 pll_locked = 1'b1;
  end
  // period unrelated to the system clock on purpose
  always #185 osc_tick = ~osc_tick;
endmodule : osc_model

// File: dv/testbench.sv
// self-checking bench for the reset source controller
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, arst_n, reg_wr, reg_rd, osc_tick, pll_locked;
  logic        clk_en, pll_in_use;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [7:0]  src;
  logic        power_save_instruction_sleep, power_save_instruction_idle, deep_sleep_enable, fuse_watchdog_enable;
  logic        clock_switch_enable, master_reset_n, code_run, watchdog_enable;
  logic        flash_bias_in_sleep, regulator_standby_in_sleep, failsafe_monitor_en;
  logic [2:0]  fuse_oscillator_select, current_oscillator_field, reset_clock_select;
  int          errors, compares, cycles;
  reset_source_controller #(.POR_CYCLES(5), .POWER_UP_TIMER_CYCLES(20), .FAILSAFE_CLOCK_MONITOR_CYCLES(3)) u_reset_source_controller (
    .clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .external_reset_pin_n(~src[6]),
    .brown_out_reset(src[7]), .osc_tick(osc_tick), .pll_locked(pll_locked), .instr_reset(src[0]),
    .watchdog_timeout(src[1]), .config_mismatch(src[2]), .trap_conflict(src[3]), .bad_opcode(src[4]),
    .uninit_register_reset(src[5]), .power_save_instruction_sleep(power_save_instruction_sleep), .power_save_instruction_idle(power_save_instruction_idle),
    .deep_sleep_enable(deep_sleep_enable), .fuse_watchdog_enable(fuse_watchdog_enable),
    .clock_switch_enable(clock_switch_enable), .fuse_oscillator_select(fuse_oscillator_select),
    .current_oscillator_field(current_oscillator_field), .pll_in_use(pll_in_use),
    .master_reset_n(master_reset_n), .code_run(code_run), .reset_clock_select(reset_clock_select),
    .watchdog_enable(watchdog_enable), .flash_bias_in_sleep(flash_bias_in_sleep),
    .regulator_standby_in_sleep(regulator_standby_in_sleep), .failsafe_monitor_en(failsafe_monitor_en));
  osc_model u_osc_model (.osc_tick(osc_tick), .pll_locked(pll_locked));
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] a, logic [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk("rdata", e, reg_rdata);
  endtask : rd
  task automatic wait_mrn(logic v);
    int n = 0;
    while (master_reset_n !== v && n < 300)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("master_reset_n", 16'(v), 16'(master_reset_n));
  endtask : wait_mrn
  // sources held three cycles so the pin synchroniser sees them
  task automatic pulse(int i);
    @(posedge clk_sys);
    src <= 8'(1 << i);
    repeat (3) @(posedge clk_sys);
    src <= '0;
    wait_mrn(1'b0);
    wait_mrn(1'b1);
  endtask : pulse
  task automatic t_por(logic [15:0] sel);
    wait_mrn(1'b1);
    chk("code_run", 16'h0, 16'(code_run));
    rd(4'h0, 16'h0003);
    chk("select", sel, 16'(reset_clock_select));
    chk("standby", 16'h1, 16'(regulator_standby_in_sleep));
  endtask : t_por
  task automatic t_wr();
    wr(4'h0, 16'hffff);
    rd(4'h0, 16'hc3ff);
    chk("master_reset_n", 16'h1, 16'(master_reset_n));
    chk("bias", 16'h1, 16'(flash_bias_in_sleep));
    chk("wdt", 16'h1, 16'(watchdog_enable));
    wr(4'h0, 16'h0000);
    wr(4'hf, 16'hffff);
    rd(4'h0, 16'h0000);
    rd(4'hf, 16'h0000);
    chk("wdt", 16'h0, 16'(watchdog_enable));
    @(posedge clk_sys);
    fuse_watchdog_enable <= 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("wdt", 16'h1, 16'(watchdog_enable));
  endtask : t_wr
  task automatic t_src();
    logic [15:0] flag [8] = '{16'h0040, 16'h0010, 16'h0200, 16'h8000,
                              16'h4000, 16'h4000, 16'h0080, 16'h0002};
    wr(4'h1, 16'h5a3c);
    for (int i = 0; i < 8; i++)
    begin
      wr(4'h0, 16'h0000);
      pulse(i);
      rd(4'h0, flag[i]);
      chk("select", (i inside {0, 1, 6}) ? 16'h5 : 16'h2, 16'(reset_clock_select));
    end
    chk("code_run", 16'h0, 16'(code_run));
    rd(4'h1, 16'h5a3c);
  endtask : t_src
  task automatic t_psave();
    wr(4'h0, 16'h0010);
    deep_sleep_enable <= 1'b1;
    power_save_instruction_idle <= 1'b1;
    @(posedge clk_sys);
    power_save_instruction_idle <= 1'b0;
    power_save_instruction_sleep <= 1'b1;
    @(posedge clk_sys);
    power_save_instruction_sleep <= 1'b0;
    rd(4'h0, 16'h040c);
    wr(4'h0, 16'h0400);
    rd(4'h0, 16'h0400);
    wr(4'h0, 16'h0000);
    rd(4'h0, 16'h0000);
  endtask : t_psave
  task automatic t_cse();
    @(posedge clk_sys);
    clock_switch_enable <= 1'b0;
    fuse_oscillator_select <= 3'h6;
    pulse(0);
    @(negedge clk_sys);
    chk("select", 16'h6, 16'(reset_clock_select));
  endtask : t_cse
  task automatic t_run();
    int n = 0;
    while (code_run !== 1'b1 && n < 6000)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("code_run", 16'h1, 16'(code_run));
    rd(4'h2, 16'h006f);
    pulse(1);
    @(negedge clk_sys);
    chk("code_run", 16'h1, 16'(code_run));
  endtask : t_run
  // a write while the clock enable is low must leave no trace
  task automatic t_freeze();
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(4'h0, 16'h0020);
    clk_en <= 1'b1;
    rd(4'h0, 16'h0000);
  endtask : t_freeze
  // power-on reset in mid-run clears the flags gathered so far
  task automatic t_rst();
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_por(16'h6);
  endtask : t_rst
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // a hung wait ends here as a mismatch
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      report_and_stop();
    end
  end
  initial
  begin
    {errors, compares, cycles} = '0;
    {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata, src} = '0;
    {power_save_instruction_sleep, power_save_instruction_idle, deep_sleep_enable, fuse_watchdog_enable} = '0;
    {clk_en, pll_in_use} = 2'h3;
    clock_switch_enable = 1'b1;
    fuse_oscillator_select = 3'h2;
    current_oscillator_field = 3'h5;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_por(16'h2);
    t_wr();
    t_src();
    t_psave();
    t_freeze();
    t_cse();
    t_run();
    t_rst();
    report_and_stop();
  end
endmodule : testbench
bind reset_source_controller rsc_monitor #(.POR_CYCLES(POR_CYCLES), .POWER_UP_TIMER_CYCLES(POWER_UP_TIMER_CYCLES),
  .FAILSAFE_CLOCK_MONITOR_CYCLES(FAILSAFE_CLOCK_MONITOR_CYCLES)) u_rsc_monitor (.*);
